/* File: core/emt_params.svh */
`ifndef EMT_PARAMS_SVH
`define EMT_PARAMS_SVH

// Register indices; byte address is four times the index
`define EMT_IDX_CTRL 16'h0122
`define EMT_IDX_POS 16'h0126
`define EMT_IDX_PER 16'h0128
`define EMT_IDX_STAT 16'h0130
`define EMT_IDX_MASK 16'h0131

// Reset values
`define EMT_CTRL_RST 16'h0000
`define EMT_POS_RST 16'h0000
`define EMT_PER_RST 16'hFFFF

// Control field positions and writable bits
`define EMT_CTRL_WMASK 16'hAFFF
`define EMT_BIT_ERR 15
`define EMT_BIT_SIDL 13
`define EMT_BIT_DIR 11
`define EMT_MODE_HI 10
`define EMT_MODE_LO 8
`define EMT_BIT_DSRC 0

// Status and mask bit of the shared interrupt flag
`define EMT_BIT_FLAG 0

`endif

/* File: core/emt_pkg.sv */
package emt_pkg;

   typedef enum logic [2:0]
   {
      EMT_MODE_OFF = 3'h0,
      EMT_MODE_TIMER = 3'h1,
      EMT_MODE_X2_IDX = 3'h4,
      EMT_MODE_X2_MAX = 3'h5,
      EMT_MODE_X4_IDX = 3'h6,
      EMT_MODE_X4_MAX = 3'h7
   } emt_mode_t;

   typedef enum logic [2:0]
   {
      EMT_BUS_IDLE = 3'b001,
      EMT_BUS_WRITE = 3'b010,
      EMT_BUS_READ = 3'b100
   } emt_bus_t;

endpackage

/* File: core/emt_timer.sv */
// Local design decisions: register access over AHB-Lite and the register offsets.
`include "emt_params.svh"
`timescale 1ns/100ps
`default_nettype none

module emt_timer
   import emt_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Encoder pins
   input wire logic phase_a_input,
   input wire logic phase_b_input,
   // Power state and other module events
   input wire logic cpu_sleep,
   input wire logic cpu_idle,
   input wire logic encoder_event,
   // Interrupt
   output logic irq
);

   emt_bus_t bus_q;
   logic [15:0] addr_idx_q;
   logic addr_ok_q;
   logic [15:0] ctrl_q;
   logic [15:0] pos_q;
   logic [15:0] per_q;
   logic flag_q;
   logic enable_q;
   logic a_s1_q;
   logic a_s2_q;
   logic a_s3_q;
   logic b_s1_q;
   logic b_s2_q;
   logic pend_q;
   logic hready_q;
   logic [31:0] hrdata_q;
   logic irq_q;

   logic accept;
   logic wr_now;
   logic pos_wr;
   logic per_wr;
   logic ctrl_wr;
   logic stat_wr;
   logic mask_wr;
   logic timer_mode;
   logic run;
   logic a_edge;
   logic cnt_evt;
   logic step;
   logic dir_up;
   logic match_evt;
   logic flag_d;
   logic enable_d;

   // Bus slave: writes finish with no wait, reads take one wait state
   assign accept = hsel && htrans[1] && hready;
   assign wr_now = (bus_q == EMT_BUS_WRITE) && addr_ok_q;
   assign ctrl_wr = wr_now && (addr_idx_q == `EMT_IDX_CTRL);
   assign pos_wr = wr_now && (addr_idx_q == `EMT_IDX_POS);
   assign per_wr = wr_now && (addr_idx_q == `EMT_IDX_PER);
   assign stat_wr = wr_now && (addr_idx_q == `EMT_IDX_STAT);
   assign mask_wr = wr_now && (addr_idx_q == `EMT_IDX_MASK);

   // Unmapped or misaligned transfers still finish with an OKAY response
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bus_q <= EMT_BUS_IDLE;
         addr_idx_q <= 16'h0000;
         addr_ok_q <= 1'b0;
         hready_q <= 1'b1;
      end
      else if (bus_q == EMT_BUS_READ && !hready_q)
      begin
         hready_q <= 1'b1;
      end
      else if (accept)
      begin
         bus_q <= hwrite ? EMT_BUS_WRITE : EMT_BUS_READ;
         addr_idx_q <= haddr[17:2];
         addr_ok_q <= (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
         hready_q <= hwrite;
      end
      else
      begin
         bus_q <= EMT_BUS_IDLE;
         hready_q <= 1'b1;
      end
   end

   // Read data is built during the wait state, after any earlier write landed
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata_q <= 32'h0000_0000;
      end
      else if (bus_q == EMT_BUS_READ && !hready_q)
      begin
         hrdata_q <= 32'h0000_0000;
         if (addr_ok_q)
         begin
            unique case (addr_idx_q)
               `EMT_IDX_CTRL: hrdata_q[15:0] <= ctrl_q;
               `EMT_IDX_POS: hrdata_q[15:0] <= pos_q;
               `EMT_IDX_PER: hrdata_q[15:0] <= per_q;
               `EMT_IDX_STAT: hrdata_q[`EMT_BIT_FLAG] <= flag_q;
               `EMT_IDX_MASK: hrdata_q[`EMT_BIT_FLAG] <= enable_q;
               default: hrdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign hreadyout = hready_q;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   // Control register; stop-in-idle comes out of reset cleared
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_q <= `EMT_CTRL_RST;
      end
      else if (ctrl_wr)
      begin
         ctrl_q <= hwdata[15:0] & `EMT_CTRL_WMASK;
      end
   end

   // Phase A has a third stage so that its rising edge can be found
   // Pin synchronisers; first stages feed only the second stages
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         a_s1_q <= 1'b0;
         a_s2_q <= 1'b0;
         a_s3_q <= 1'b0;
         b_s1_q <= 1'b0;
         b_s2_q <= 1'b0;
      end
      else
      begin
         a_s1_q <= phase_a_input;
         a_s2_q <= a_s1_q;
         a_s3_q <= a_s2_q;
         b_s1_q <= phase_b_input;
         b_s2_q <= b_s1_q;
      end
   end

   assign timer_mode = (ctrl_q[`EMT_MODE_HI:`EMT_MODE_LO] == EMT_MODE_TIMER);
   // Sleep always halts; idle halts only with stop-in-idle set
   assign run = timer_mode && !cpu_sleep && !(cpu_idle && ctrl_q[`EMT_BIT_SIDL]);
   assign a_edge = a_s2_q && !a_s3_q;
   assign cnt_evt = a_edge || pend_q;
   assign step = run && cnt_evt && !pos_wr && !per_wr;
   assign dir_up = ctrl_q[`EMT_BIT_DSRC] ? b_s2_q : ctrl_q[`EMT_BIT_DIR];
   assign match_evt = step && (dir_up ? (pos_q == per_q) : (pos_q == 16'h0000));

   // A count edge colliding with a count or period write is replayed next cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pend_q <= 1'b0;
      end
      else if (run)
      begin
         pend_q <= cnt_evt && (pos_wr || per_wr);
      end
   end

   // Count register is shared with encoder mode and kept across mode changes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pos_q <= `EMT_POS_RST;
      end
      else if (pos_wr)
      begin
         pos_q <= hwdata[15:0];
      end
      else if (step)
      begin
         if (dir_up)
         begin
            pos_q <= (pos_q == per_q) ? 16'h0000 : pos_q + 16'h0001;
         end
         else
         begin
            pos_q <= (pos_q == 16'h0000) ? per_q : pos_q - 16'h0001;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         per_q <= `EMT_PER_RST;
      end
      else if (per_wr)
      begin
         per_q <= hwdata[15:0];
      end
   end

   // Shared flag: set wins over a write-one clear
   always_comb
   begin
      flag_d = flag_q;
      if (stat_wr && hwdata[`EMT_BIT_FLAG])
      begin
         flag_d = 1'b0;
      end
      if (match_evt || (encoder_event && !cpu_sleep))
      begin
         flag_d = 1'b1;
      end
      enable_d = mask_wr ? hwdata[`EMT_BIT_FLAG] : enable_q;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         flag_q <= 1'b0;
         enable_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d;
         enable_q <= enable_d;
         irq_q <= flag_d && enable_d;
      end
   end

   assign irq = irq_q;

   // Checks
   // Most checks look one edge after the cause, at registered state

   a_mode_select: assert property (@(posedge hclk) disable iff (!hresetn)
      (!timer_mode && !pos_wr) |=> $stable(pos_q))
      else $error("count moved outside timer mode");

   a_edge_sync: assert property (@(posedge hclk) disable iff (!hresetn)
      (a_edge && !pend_q) |-> ($past(phase_a_input, 2) && !$past(phase_a_input, 3)))
      else $error("count edge not from synchronised phase A");

   a_count_up: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && dir_up && pos_q != per_q) |=> (pos_q == $past(pos_q) + 16'h0001))
      else $error("up count did not increment");

   a_count_down: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && !dir_up && pos_q != 16'h0000) |=> (pos_q == $past(pos_q) - 16'h0001))
      else $error("down count did not decrement");

   a_dir_source: assert property (@(posedge hclk) disable iff (!hresetn)
      ctrl_q[`EMT_BIT_DSRC] |-> (dir_up == $past(phase_b_input, 2)))
      else $error("direction not taken from phase B");

   a_wrap_match: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && dir_up && pos_q == per_q) |=> (pos_q == 16'h0000 && flag_q))
      else $error("period match did not wrap and flag");

   a_under_reload: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && !dir_up && pos_q == 16'h0000) |=> (pos_q == $past(per_q) && flag_q))
      else $error("underflow did not reload period");

   a_sleep_halt: assert property (@(posedge hclk) disable iff (!hresetn)
      (cpu_sleep && !pos_wr) |=> ($stable(pos_q) && (!flag_q || $past(flag_q))))
      else $error("activity during sleep");

   a_idle_stop: assert property (@(posedge hclk) disable iff (!hresetn)
      (cpu_idle && ctrl_q[`EMT_BIT_SIDL] && !pos_wr) |=> $stable(pos_q))
      else $error("counted in idle with stop bit set");

   a_idle_run: assert property (@(posedge hclk) disable iff (!hresetn)
      (timer_mode && cpu_idle && !cpu_sleep && !ctrl_q[`EMT_BIT_SIDL]) |-> run)
      else $error("timer halted in idle with stop bit clear");

   a_pend_replay: assert property (@(posedge hclk) disable iff (!hresetn)
      (run && a_edge && pos_wr) |=> (pend_q && pos_q == $past(hwdata[15:0])))
      else $error("colliding count edge was dropped");

   a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      (flag_q && !(stat_wr && hwdata[`EMT_BIT_FLAG])) |=> flag_q)
      else $error("flag cleared without software");

   a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_q == (flag_q && enable_q))
      else $error("interrupt not gated by enable");

   a_reset_idle: assert property (@(posedge hclk)
      $rose(hresetn) |-> !ctrl_q[`EMT_BIT_SIDL])
      else $error("stop-in-idle not cleared by reset");

   // Flag, write, direction, sleep, replay and interrupt mask checks
   a_match_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      match_evt |=> flag_q)
      else $error("period match did not set flag");

   a_event_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      (encoder_event && !cpu_sleep) |=> flag_q)
      else $error("module event did not set flag");

   a_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (stat_wr && hwdata[`EMT_BIT_FLAG] && !match_evt && !encoder_event) |=> !flag_q)
      else $error("write-one did not clear flag");

   a_dir_bit: assert property (@(posedge hclk) disable iff (!hresetn)
      !ctrl_q[`EMT_BIT_DSRC] |-> (dir_up == ctrl_q[`EMT_BIT_DIR]))
      else $error("direction not taken from control bit");

   a_sleep_count: assert property (@(posedge hclk) disable iff (!hresetn)
      (cpu_sleep && !pos_wr) |=> $stable(pos_q))
      else $error("timer counted during sleep");

   a_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
      pos_wr |=> (pos_q == $past(hwdata[15:0])))
      else $error("count write did not land");

   a_period_write: assert property (@(posedge hclk) disable iff (!hresetn)
      per_wr |=> (per_q == $past(hwdata[15:0])))
      else $error("period write did not land");

   a_pend_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (pend_q && run && !pos_wr && !per_wr && !a_edge) |=> !pend_q)
      else $error("replayed count edge applied twice");

   a_irq_mask: assert property (@(posedge hclk) disable iff (!hresetn)
      !enable_q |-> !irq_q)
      else $error("interrupt raised while disabled");

endmodule

`default_nettype wire

/* File: verif/emt_pin_src.sv */
`timescale 1ns/100ps
`default_nettype none

module emt_pin_src
(
   // Clock used to pace the pins
   input wire logic hclk,
   // Encoder pins
   output logic phase_a_input,
   output logic phase_b_input
);
   // The count clock stands still low between bursts
   initial
   begin
      phase_a_input = 1'b0;
      phase_b_input = 1'b0;
   end

   // Burst of n count clocks, each level held w cycles, direction level set first
   task automatic pulses(input int n, input int w, input logic up);
      phase_b_input <= up;
      repeat (n)
      begin
         repeat (w) @(posedge hclk);
         phase_a_input <= 1'b1;
         repeat (w) @(posedge hclk);
         phase_a_input <= 1'b0;
      end
   endtask
endmodule

`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "emt_params.svh"

module testbench;
   typedef struct {logic [15:0] ctrl; logic [15:0] per; logic [15:0] pos; int n; logic b; logic sl; logic id;
      logic [15:0] exp_pos; logic exp_flag;} emt_row_t;
   localparam logic [31:0] a_ctrl = {14'h0, `EMT_IDX_CTRL, 2'h0};
   localparam logic [31:0] a_pos = {14'h0, `EMT_IDX_POS, 2'h0};
   localparam logic [31:0] a_per = {14'h0, `EMT_IDX_PER, 2'h0};
   localparam logic [31:0] a_stat = {14'h0, `EMT_IDX_STAT, 2'h0};
   localparam logic [31:0] a_mask = {14'h0, `EMT_IDX_MASK, 2'h0};
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic phase_a_input, phase_b_input, cpu_sleep, cpu_idle, encoder_event;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int err_total, check_count;
   // Up, down, wrap, phase B source, mode off, sleep, idle with stop bit clear and set
   emt_row_t rows [10] = '{
      '{16'h0900, 16'h0010, 16'h0005, 3, 1'b0, 1'b0, 1'b0, 16'h0008, 1'b0},
      '{16'h0100, 16'h0010, 16'h0005, 3, 1'b1, 1'b0, 1'b0, 16'h0002, 1'b0},
      '{16'h0900, 16'h0004, 16'h0003, 3, 1'b0, 1'b0, 1'b0, 16'h0001, 1'b1},
      '{16'h0100, 16'h0007, 16'h0001, 3, 1'b0, 1'b0, 1'b0, 16'h0006, 1'b1},
      '{16'h0101, 16'h0010, 16'h0005, 2, 1'b1, 1'b0, 1'b0, 16'h0007, 1'b0},
      '{16'h0901, 16'h0010, 16'h0005, 2, 1'b0, 1'b0, 1'b0, 16'h0003, 1'b0},
      '{16'h0000, 16'h0010, 16'h0005, 3, 1'b1, 1'b0, 1'b0, 16'h0005, 1'b0},
      '{16'h0900, 16'h0006, 16'h0005, 3, 1'b1, 1'b1, 1'b0, 16'h0005, 1'b0},
      '{16'h0900, 16'h0010, 16'h0005, 3, 1'b1, 1'b0, 1'b1, 16'h0008, 1'b0},
      '{16'h2900, 16'h0006, 16'h0005, 3, 1'b1, 1'b0, 1'b1, 16'h0005, 1'b0}};

   assign hready = hreadyout;

   emt_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .phase_a_input(phase_a_input), .phase_b_input(phase_b_input), .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
      .encoder_event(encoder_event), .irq(irq));

   emt_pin_src src (.hclk(hclk), .phase_a_input(phase_a_input), .phase_b_input(phase_b_input));

   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   task automatic summarize();
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Single word transfer; each phase waits for hready under a bound
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hready !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hready !== 1'b1 && n < 100);
      d = hrdata;
      if (n >= 100)
      begin
         err_total++;
         $display("[FAIL] %0t bus wait ran out", $time);
         summarize();
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] e, input string s);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0, x);
      chk(x, e, s);
   endtask

   initial
   begin
      repeat (100000) @(posedge hclk);
      err_total++;
      $display("[FAIL] %0t run did not finish", $time);
      summarize();
   end

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      cpu_sleep = 1'b0;
      cpu_idle = 1'b0;
      encoder_event = 1'b0;
      err_total = 0;
      check_count = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (rows[i])
      begin
         wr(a_per, {16'h0, rows[i].per});
         wr(a_pos, {16'h0, rows[i].pos});
         wr(a_ctrl, {16'h0, rows[i].ctrl});
         wr(a_stat, 32'h1);
         cpu_sleep <= rows[i].sl;
         cpu_idle <= rows[i].id;
         src.pulses(rows[i].n, 3, rows[i].b);
         repeat (6) @(posedge hclk);
         cpu_sleep <= 1'b0;
         cpu_idle <= 1'b0;
         @(posedge hclk);
         rdc(a_pos, {16'h0, rows[i].exp_pos}, "count");
         rdc(a_stat, {31'h0, rows[i].exp_flag}, "match flag");
      end
      wr(a_pos, 32'h1234);
      wr(a_ctrl, 32'h0600);
      wr(a_ctrl, 32'h0100);
      rdc(a_pos, 32'h1234, "count after mode change");
      // Count edge lands in the same cycle as a count write
      wr(a_per, 32'h0100);
      wr(a_ctrl, 32'h0900);
      fork
         src.pulses(1, 3, 1'b1);
         begin
            repeat (4) @(posedge hclk);
            wr(a_pos, 32'h0010);
         end
      join
      repeat (4) @(posedge hclk);
      rdc(a_pos, 32'h0011, "count edge kept across write");
      cpu_sleep <= 1'b1;
      encoder_event <= 1'b1;
      @(posedge hclk);
      cpu_sleep <= 1'b0;
      encoder_event <= 1'b0;
      rdc(a_stat, 32'h0, "no event in sleep");
      // Fast partner drives one wrap with the interrupt enabled
      wr(a_per, 32'h4);
      wr(a_pos, 32'h4);
      wr(a_ctrl, 32'h0900);
      wr(a_stat, 32'h1);
      wr(a_mask, 32'h1);
      chk({31'h0, irq}, 32'h0, "irq before match");
      src.pulses(1, 2, 1'b1);
      repeat (6) @(posedge hclk);
      chk({31'h0, irq}, 32'h1, "irq on match");
      rdc(a_pos, 32'h0, "wrap to zero");
      repeat (20) @(posedge hclk);
      rdc(a_stat, 32'h1, "flag sticky");
      wr(a_mask, 32'h0);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr(a_mask, 32'h1);
      wr(a_stat, 32'h1);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0, "irq after clear");
      encoder_event <= 1'b1;
      @(posedge hclk);
      encoder_event <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h1, "irq from other event");
      wr(32'h0000_0500, 32'hFFFF);
      rdc(32'h0000_0500, 32'h0, "unmapped read");
      chk({31'h0, hresp}, 32'h0, "okay response");
      wr(a_ctrl, 32'hFFFF_FFFF);
      rdc(a_ctrl, 32'h0000_AFFF, "control writable bits");
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk({31'h0, irq}, 32'h0, "irq after reset");
      rdc(a_ctrl, 32'h0, "control reset");
      rdc(a_pos, 32'h0, "count reset");
      rdc(a_per, 32'h0000_FFFF, "period reset");
      rdc(a_stat, 32'h0, "status reset");
      rdc(a_mask, 32'h0, "mask reset");
      summarize();
   end
endmodule

`default_nettype wire
